//--- uart_cfg_consts.svh
// offsets, field positions, reset values and widths for the mode and baud block
`ifndef UART_CFG_CONSTS_SVH
`define UART_CFG_CONSTS_SVH
`define OFS_CORE_CTRL     8'h00
`define OFS_MODE_CTRL     8'h08
`define OFS_BAUD_DIVIDER  8'h0c
`define OFS_ERR_STATUS    8'h1c
`define BIT_ERR_IRQ_EN    0
`define BIT_IR_EN         1
`define BIT_IR_LOW_POWER  2
`define BIT_HALF_DUPLEX   3
`define BIT_SC_REJECT     4
`define BIT_XCVR_EN       0
`define BIT_OVERSAMPLE_8X 1
`define BIT_SYNC_SLAVE    2
`define BIT_DIV_RSV_8X    3
`define RST_BAUD_DIVIDER  16'h0000
`define RST_MODE_CTRL     5'h00
`define RST_CORE_CTRL     3'h0
`define DIV_W             16
`endif

//--- uart_cfg_pkg.sv
// types shared by the mode and baud configuration block
package uart_cfg_pkg;
   typedef struct packed {
      logic smartcard_parity_reject_enable;
      logic half_duplex_select;
      logic infrared_low_power;
      logic infrared_enable;
      logic error_irq_enable;
   } mode_ctrl_t;
   typedef struct packed {
      logic sync_slave_mode;
      logic oversample_by_eight;
      logic transceiver_enable;
   } core_ctrl_t;
   typedef struct packed {
      logic slave_underrun_flag;
      logic noise_flag;
      logic overrun_flag;
      logic framing_error_flag;
   } err_flags_t;
   typedef enum logic [1:0] {
      SEL_NONE,
      SEL_CORE,
      SEL_MODE,
      SEL_BAUD
   } wsel_t;
endpackage

//--- uart_mode_baud_cfg.sv
// mode-control bits, baud divider and error interrupt of the serial transceiver
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
`include "uart_cfg_consts.svh"

module uart_mode_baud_cfg #(
   parameter bit HAS_IRDA      = 1'b1,
   parameter bit HAS_SMARTCARD = 1'b1
) (
   // clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // wishbone slave
   input  wire logic                      cyc_i,
   input  wire logic                      stb_i,
   input  wire logic                      we_i,
   input  wire logic [7:0]                adr_i,
   input  wire logic [3:0]                sel_i,
   input  wire logic [31:0]               dat_i,
   output logic      [31:0]               dat_o,
   output logic                           ack_o,
   // datapath status and auto baud detection
   input  wire uart_cfg_pkg::err_flags_t  err_flags_i,
   input  wire logic                      autobaud_load_i,
   input  wire logic [`DIV_W-1:0]         autobaud_value_i,
   // configuration to the transceiver
   output uart_cfg_pkg::mode_ctrl_t       mode_o,
   output uart_cfg_pkg::core_ctrl_t       core_o,
   output logic      [`DIV_W-1:0]         baud_divisor_value_o,
   output logic                           error_irq_o
);
   import uart_cfg_pkg::*;

   mode_ctrl_t         mode_r;
   core_ctrl_t         core_r;
   logic [`DIV_W-1:0]  baud_divider_r;
   logic [`DIV_W-1:0]  divisor_nxt;
   logic [31:0]        rdata_nxt;
   logic               ack_r;
   logic               wr_commit;
   logic               locked;
   logic               irq_nxt;
   wsel_t              wsel;

   // address decode shared by read and write paths
   function automatic wsel_t decode(input logic [7:0] a);
      case ({a[7:2], 2'b00})
         `OFS_CORE_CTRL:    decode = SEL_CORE;
         `OFS_MODE_CTRL:    decode = SEL_MODE;
         `OFS_BAUD_DIVIDER: decode = SEL_BAUD;
         default:           decode = SEL_NONE;
      endcase
   endfunction

   assign wsel      = decode(adr_i);
   assign locked    = core_r.transceiver_enable;
   // a write lands on the edge where the master sees ack
   assign wr_commit = cyc_i & stb_i & we_i & ack_r;

   // one wait state: ack one edge after the request, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= cyc_i & stb_i & ~ack_r;
      end
   end

   // enable, oversampling and sync-slave bits are always writable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_r <= `RST_CORE_CTRL;
      end else if (wr_commit && wsel == SEL_CORE && sel_i[0]) begin
         core_r.transceiver_enable  <= dat_i[`BIT_XCVR_EN];
         core_r.oversample_by_eight <= dat_i[`BIT_OVERSAMPLE_8X];
         core_r.sync_slave_mode     <= dat_i[`BIT_SYNC_SLAVE];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= `RST_MODE_CTRL;
      end else if (wr_commit && wsel == SEL_MODE && sel_i[0]) begin
         mode_r.error_irq_enable <= dat_i[`BIT_ERR_IRQ_EN];
         // the rest hold their value while the transceiver runs
         if (!locked) begin
            mode_r.half_duplex_select <= dat_i[`BIT_HALF_DUPLEX];
            mode_r.infrared_low_power <= HAS_IRDA & dat_i[`BIT_IR_LOW_POWER];
            mode_r.infrared_enable    <= HAS_IRDA & dat_i[`BIT_IR_EN];
            mode_r.smartcard_parity_reject_enable <=
               HAS_SMARTCARD & dat_i[`BIT_SC_REJECT];
         end
      end
   end

   // auto baud detection overrides software and ignores the lock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         baud_divider_r <= `RST_BAUD_DIVIDER;
      end else if (autobaud_load_i) begin
         baud_divider_r <= autobaud_value_i;
      end else if (wr_commit && wsel == SEL_BAUD && !locked) begin
         for (int b = 0; b < 2; b++) begin
            if (sel_i[b]) begin
               baud_divider_r[b*8 +: 8] <= dat_i[b*8 +: 8];
            end
         end
      end
   end

   // divider bit 3 is left out in 8x mode, software must keep it clear
   always_comb begin
      if (core_r.oversample_by_eight) begin
         divisor_nxt = {baud_divider_r[15:4], baud_divider_r[2:0], 1'b0};
      end else begin
         divisor_nxt = baud_divider_r;
      end
   end

   // underrun only counts as an error in synchronous slave mode
   always_comb begin
      irq_nxt = mode_r.error_irq_enable &
                (err_flags_i.framing_error_flag | err_flags_i.overrun_flag |
                 err_flags_i.noise_flag |
                 (err_flags_i.slave_underrun_flag & core_r.sync_slave_mode));
   end

   // reserved bits above the fields read as zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (wsel)
         SEL_CORE: begin
            rdata_nxt[`BIT_XCVR_EN]    = core_r.transceiver_enable;
            rdata_nxt[`BIT_OVERSAMPLE_8X] = core_r.oversample_by_eight;
            rdata_nxt[`BIT_SYNC_SLAVE] = core_r.sync_slave_mode;
         end
         SEL_MODE: begin
            rdata_nxt[`BIT_ERR_IRQ_EN]   = mode_r.error_irq_enable;
            rdata_nxt[`BIT_IR_EN]        = mode_r.infrared_enable;
            rdata_nxt[`BIT_IR_LOW_POWER] = mode_r.infrared_low_power;
            rdata_nxt[`BIT_HALF_DUPLEX]  = mode_r.half_duplex_select;
            rdata_nxt[`BIT_SC_REJECT]    = mode_r.smartcard_parity_reject_enable;
         end
         SEL_BAUD: begin
            rdata_nxt[`DIV_W-1:0] = baud_divider_r;
         end
         default: begin
            if ({adr_i[7:2], 2'b00} == `OFS_ERR_STATUS) begin
               rdata_nxt[3:0] = err_flags_i;
               rdata_nxt[4]   = error_irq_o;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (cyc_i && stb_i && !ack_r) begin
         dat_o <= rdata_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         baud_divisor_value_o <= `RST_BAUD_DIVIDER;
         error_irq_o          <= 1'b0;
      end else begin
         baud_divisor_value_o <= divisor_nxt;
         error_irq_o          <= irq_nxt;
      end
   end

   assign ack_o  = ack_r;
   assign mode_o = mode_r;
   assign core_o = core_r;

   // checks
   a_reject_locked: assert property (@(posedge clk_i) disable iff (rst_i)
      locked |=> $stable(mode_r.smartcard_parity_reject_enable))
      else $error("parity reject bit changed while enabled");

   a_reject_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_commit && wsel == SEL_MODE && sel_i[0] && !locked && HAS_SMARTCARD)
      |=> mode_r.smartcard_parity_reject_enable == $past(dat_i[4]))
      else $error("parity reject bit not written");

   a_duplex_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_commit && wsel == SEL_MODE && sel_i[0] && !locked)
      |=> mode_r.half_duplex_select == $past(dat_i[3]))
      else $error("half duplex bit not written");

   a_lowpower_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_commit && wsel == SEL_MODE && sel_i[0] && !locked && HAS_IRDA)
      |=> mode_r.infrared_low_power == $past(dat_i[2]))
      else $error("infrared low power bit not written");

   a_irenable_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_commit && wsel == SEL_MODE && sel_i[0] && !locked && HAS_IRDA)
      |=> mode_r.infrared_enable == $past(dat_i[1]))
      else $error("infrared enable bit not written");

   a_irenable_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !(wr_commit && wsel == SEL_MODE) |=> $stable(mode_r.infrared_enable))
      else $error("infrared enable changed without software");

   a_mode_locked: assert property (@(posedge clk_i) disable iff (rst_i)
      locked |=> $stable(mode_r.half_duplex_select) && $stable(mode_r.infrared_low_power)
                 && $stable(mode_r.infrared_enable))
      else $error("locked mode bit changed");

   a_absent_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (!HAS_IRDA |-> !mode_r.infrared_enable && !mode_r.infrared_low_power) and
      (!HAS_SMARTCARD |-> !mode_r.smartcard_parity_reject_enable))
      else $error("absent feature bit set");

   a_errirq_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_commit && wsel == SEL_MODE && sel_i[0])
      |=> mode_r.error_irq_enable == $past(dat_i[0]))
      else $error("error interrupt enable not written");

   a_err_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_r.error_irq_enable && (err_flags_i[2:0] != 3'h0)) |=> error_irq_o)
      else $error("error interrupt missing");

   a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
      !mode_r.error_irq_enable |=> !error_irq_o)
      else $error("error interrupt while masked");

   a_underrun_sync: assert property (@(posedge clk_i) disable iff (rst_i)
      (err_flags_i == 4'h8 && !core_r.sync_slave_mode) |=> !error_irq_o)
      else $error("underrun raised interrupt outside sync slave");

   a_underrun_slave: assert property (@(posedge clk_i) disable iff (rst_i)
      (err_flags_i == 4'h8 && core_r.sync_slave_mode && mode_r.error_irq_enable)
      |=> error_irq_o)
      else $error("underrun missed interrupt in sync slave");

   a_div_locked: assert property (@(posedge clk_i) disable iff (rst_i)
      (locked && !autobaud_load_i) |=> $stable(baud_divider_r))
      else $error("divider changed while enabled");

   a_div_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_commit && wsel == SEL_BAUD && !locked && !autobaud_load_i && sel_i == 4'hf)
      |=> baud_divider_r == $past(dat_i[15:0]))
      else $error("divider write not taken");

   a_autobaud: assert property (@(posedge clk_i) disable iff (rst_i)
      autobaud_load_i |=> baud_divider_r == $past(autobaud_value_i))
      else $error("auto baud value not loaded");

   a_div_reset: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> baud_divider_r == 16'h0000 ##1 baud_divisor_value_o == 16'h0000)
      else $error("divider not zero after reset");

   a_div_16x: assert property (@(posedge clk_i) disable iff (rst_i)
      !core_r.oversample_by_eight |=> baud_divisor_value_o == $past(baud_divider_r))
      else $error("16x divisor mismatch");

   a_div_8x: assert property (@(posedge clk_i) disable iff (rst_i)
      core_r.oversample_by_eight |=> baud_divisor_value_o ==
         {$past(baud_divider_r[15:4]), $past(baud_divider_r[2:0]), 1'b0})
      else $error("8x divisor mismatch");

   a_locked_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_commit && locked && wsel == SEL_BAUD && !autobaud_load_i)
      |=> baud_divider_r == $past(baud_divider_r))
      else $error("locked divider took a write");

   // bus handshake: one wait state, then a single-cycle acknowledge
   a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_r) |=> ack_r)
      else $error("request not acknowledged");

   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_r |=> !ack_r)
      else $error("acknowledge held too long");

endmodule // uart_mode_baud_cfg

//--- uart_line_model.sv
// model of the line-side datapath feeding error flags and auto baud results
`timescale 1ns/100ps
module uart_line_model (
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // scenario commands from the bench
   input  wire uart_cfg_pkg::err_flags_t flags_req_i,
   input  wire logic                     ab_go_i,
   input  wire logic [15:0]              ab_val_i,
   // datapath side of the configuration block
   output uart_cfg_pkg::err_flags_t      err_flags_o,
   output logic                          autobaud_load_o,
   output logic      [15:0]              autobaud_value_o
);
   import uart_cfg_pkg::*;
   // flags are levels from the receive path, held until the bench clears them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_flags_o <= '0;
      end else begin
         err_flags_o <= flags_req_i;
      end
   end
   // value is valid only with its strobe; it toggles in between so a stale capture shows
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         autobaud_load_o  <= 1'b0;
         autobaud_value_o <= 16'h0000;
      end else begin
         autobaud_load_o  <= ab_go_i;
         autobaud_value_o <= ab_go_i ? ab_val_i : ~autobaud_value_o;
      end
   end
endmodule // uart_line_model

//--- uart_mode_baud_cfg_bench.sv
// self-checking bench for the mode and baud configuration block
`timescale 1ns/100ps
`include "uart_cfg_consts.svh"
module uart_mode_baud_cfg_bench;
   import uart_cfg_pkg::*;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, error_irq_o;
   logic        autobaud_load_i, ab_go, irq_exp;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [15:0] autobaud_value_i, baud_divisor_value_o, ab_val;
   err_flags_t  err_flags_i, flags_req;
   mode_ctrl_t  mode_o, mode_lite;
   core_ctrl_t  core_o;
   int          n_fail, samples_checked;

   uart_mode_baud_cfg uart_mode_baud_cfg_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i, .dat_i, .dat_o, .ack_o, .err_flags_i, .autobaud_load_i, .autobaud_value_i,
      .mode_o, .core_o, .baud_divisor_value_o, .error_irq_o);
   // variant without infrared or smartcard support shares the bus, only its mode bits are used
   uart_mode_baud_cfg #(.HAS_IRDA(1'b0), .HAS_SMARTCARD(1'b0)) uart_mode_baud_cfg_lite_i (
      .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o(), .ack_o(),
      .err_flags_i, .autobaud_load_i, .autobaud_value_i, .mode_o(mode_lite), .core_o(),
      .baud_divisor_value_o(), .error_irq_o());
   uart_line_model uart_line_model_i (.clk_i, .rst_i, .flags_req_i(flags_req), .ab_go_i(ab_go),
      .ab_val_i(ab_val), .err_flags_o(err_flags_i), .autobaud_load_o(autobaud_load_i),
      .autobaud_value_o(autobaud_value_i));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task automatic summarize;
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // one classic cycle; read data is taken at the edge where ack is seen
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      // only the watchdog ends a wait that never sees ack
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // outputs are registered and the divisor lags once more, so let them land
   task automatic settle;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   initial begin
      repeat (4000) @(posedge clk_i);
      n_fail++;
      $display("[FAIL] %0t ns: watchdog expired", $time);
      summarize;
   end

   initial begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'h0;
      dat_i = 32'h0;
      ab_go = 1'b0;
      ab_val = 16'h0000;
      flags_req = '0;
      n_fail = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      settle;
      chk({16'h0, baud_divisor_value_o}, 32'h0);
      rdchk(`OFS_BAUD_DIVIDER, 32'h0);
      rdchk(`OFS_MODE_CTRL, 32'h0);
      $display("test reset done");
      for (int b = 0; b < 5; b++) begin
         bus(1'b1, `OFS_MODE_CTRL, 32'h1 << b);
         settle;
         chk({27'h0, mode_o}, 32'h1 << b);
         chk({27'h0, mode_lite}, (32'h1 << b) & 32'h9);
      end
      $display("test mode bits done");
      bus(1'b1, `OFS_BAUD_DIVIDER, 32'h0000abc5);
      settle;
      rdchk(`OFS_BAUD_DIVIDER, 32'h0000abc5);
      chk({16'h0, baud_divisor_value_o}, 32'h0000abc5);
      bus(1'b1, `OFS_CORE_CTRL, 32'h2);
      settle;
      chk({16'h0, baud_divisor_value_o}, 32'h0000abca);
      chk({29'h0, core_o}, 32'h2);
      $display("test divider done");
      bus(1'b1, `OFS_MODE_CTRL, 32'h1f);
      bus(1'b1, `OFS_CORE_CTRL, 32'h3);
      bus(1'b1, `OFS_MODE_CTRL, 32'h0);
      bus(1'b1, `OFS_BAUD_DIVIDER, 32'h00001111);
      settle;
      rdchk(`OFS_MODE_CTRL, 32'h1e);
      rdchk(`OFS_BAUD_DIVIDER, 32'h0000abc5);
      rdchk(`OFS_CORE_CTRL, 32'h3);
      @(posedge clk_i);
      ab_val <= 16'h1230;
      ab_go <= 1'b1;
      @(posedge clk_i);
      ab_go <= 1'b0;
      settle;
      rdchk(`OFS_BAUD_DIVIDER, 32'h00001230);
      $display("test lock done");
      bus(1'b1, `OFS_MODE_CTRL, 32'h1);
      for (int s = 0; s < 3; s++) begin
         for (int f = 0; f < 4; f++) begin
            @(posedge clk_i);
            flags_req <= err_flags_t'(4'h1 << f);
            settle;
            irq_exp = (s != 2) && (f != 3 || s == 1);
            chk({31'h0, error_irq_o}, {31'h0, irq_exp});
            rdchk(`OFS_ERR_STATUS, {27'h0, irq_exp, 4'h1 << f});
         end
         @(posedge clk_i);
         flags_req <= '0;
         bus(1'b1, s == 0 ? `OFS_CORE_CTRL : `OFS_MODE_CTRL, s == 0 ? 32'h7 : 32'h0);
      end
      $display("test error interrupt done");
      bus(1'b1, 8'h20, 32'hffffffff);
      rdchk(8'h20, 32'h0);
      $display("test unmapped done");
      summarize;
   end
endmodule // uart_mode_baud_cfg_bench
